// ==== src/mpb_memory_page_bank_decoder.sv ====
// program/constant address generation, banked register file, stack pointer
// assumes core issues at most one register access per cycle, same clock
`timescale 1ns/1ps
module mpb_memory_page_bank_decoder #(
  parameter int RAM_WORDS = 1024
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  resetn,
  // program fetch
  input  wire logic                  fetch_step,
  input  wire logic                  fetch_jump,
  input  wire logic [15:0]           fetch_target,
  input  wire logic                  vector_take,
  input  wire logic [2:0]            vector_index,
  output logic [16:0]                fetch_addr,
  // constant loads
  input  wire logic                  const_load,
  input  wire logic                  const_inc,
  input  wire logic [15:0]           const_addr,
  output logic [16:0]                const_mem_addr,
  output logic                       const_mem_rd,
  // register file access
  input  wire mpb_pkg::mpb_reg_req_s reg_req,
  output logic [7:0]                 reg_rdata,
  output logic                       reg_rvalid,
  output logic [11:0]                reg_phys,
  output logic                       reg_port_sel,
  // stack
  input  wire mpb_pkg::mpb_stack_op_e stack_op,
  input  wire logic [7:0]            stack_wdata,
  output logic [7:0]                 stack_rdata,
  output logic [7:0]                 stack_ptr,
  // register values to the core
  output logic [7:0]                 pointer_q,
  output logic                       page_q
);
  mpb_pkg::mpb_decode_s dec;
  logic [7:0]  ram [RAM_WORDS];
  logic [7:0]  constant_page_select;
  logic [7:0]  bank_group_pointer;
  logic [7:0]  scratch_user_byte;
  logic [7:0]  stack_pointer_low;
  logic [15:0] pc;
  logic [7:0]  next_cps, next_bgp, next_sub, next_spl;
  logic [15:0] next_pc;
  logic [16:0] next_fetch_addr, next_const_addr;
  logic        next_const_rd, next_rvalid, next_port;
  logic [7:0]  next_rdata, next_stack_rdata;
  logic [11:0] next_phys;
  logic        ram_we;
  logic [9:0]  ram_wa;
  logic [7:0]  ram_wd;
  logic [7:0]  ctrl_read;
  logic        wr;
  logic [7:0]  push_addr;

  mpb_bank_decode u_dec (
    .pointer (bank_group_pointer),
    .req     (reg_req),
    .dec     (dec)
  );

  // bank 0 control window readback
  always_comb begin
    unique case (dec.phys[7:0])
      mpb_pkg::ADDR_PAGE_SEL:  ctrl_read = {constant_page_select[mpb_pkg::TOGGLE_BIT_POS],
                                            mpb_pkg::PAGE_RSVD_READ,
                                            constant_page_select[mpb_pkg::PAGE_BIT_POS]};  // see RULE8
      mpb_pkg::ADDR_POINTER:   ctrl_read = bank_group_pointer;
      mpb_pkg::ADDR_SCRATCH:   ctrl_read = scratch_user_byte;                            // see RULE20
      mpb_pkg::ADDR_STACK_LOW: ctrl_read = stack_pointer_low;
      default:                 ctrl_read = mpb_pkg::UNMAPPED_READ;
    endcase
  end

  // register and stack next state
  always_comb begin
    next_cps         = constant_page_select;
    next_bgp         = bank_group_pointer;
    next_sub         = scratch_user_byte;
    next_spl         = stack_pointer_low;
    next_rdata       = reg_rdata;
    next_rvalid      = 1'b0;
    next_phys        = dec.phys;
    next_port        = dec.port && reg_req.valid;
    next_stack_rdata = stack_rdata;
    ram_we           = 1'b0;
    ram_wa           = 10'h000;
    ram_wd           = 8'h00;
    wr               = reg_req.valid && reg_req.write && dec.hit;           // see RULE21
    push_addr        = stack_pointer_low - 8'h01;
    if (reg_req.valid && !reg_req.write) begin
      next_rvalid = 1'b1;
      if (!dec.hit)
        next_rdata = mpb_pkg::UNMAPPED_READ;                                  // see RULE21
      else if (dec.ctrl)
        next_rdata = ctrl_read;
      else if (dec.phys[11:10] == 2'b00)
        next_rdata = ram[dec.phys[9:0]];                                      // see RULE9
      else
        next_rdata = mpb_pkg::UNMAPPED_READ;
    end
    if (wr && dec.ctrl) begin
      unique case (dec.phys[7:0])
        mpb_pkg::ADDR_PAGE_SEL: begin
          next_cps = {reg_req.wdata[mpb_pkg::TOGGLE_BIT_POS], 6'h00,
                      reg_req.wdata[mpb_pkg::PAGE_BIT_POS]};                   // see RULE6
        end
        mpb_pkg::ADDR_POINTER:   next_bgp = reg_req.wdata;                    // see RULE10
        mpb_pkg::ADDR_SCRATCH:   next_sub = reg_req.wdata;                    // see RULE20
        mpb_pkg::ADDR_STACK_LOW: next_spl = reg_req.wdata;
        default: ;
      endcase
    end else if (wr && !dec.port && dec.phys[11:10] == 2'b00) begin
      ram_we = 1'b1;
      ram_wa = dec.phys[9:0];
      ram_wd = reg_req.wdata;
    end
    // stack always in bank 0; call/interrupt frames are issued as pushes
    unique case (stack_op)
      mpb_pkg::MPB_OP_PUSH: begin
        next_spl = push_addr;                                                 // see RULE17 see RULE16
        if (push_addr < mpb_pkg::CTRL_WIN_LO) begin
          ram_we = 1'b1;                                                      // see RULE18
          ram_wa = {2'b00, push_addr};
          ram_wd = stack_wdata;
        end
      end
      mpb_pkg::MPB_OP_POP: begin
        next_stack_rdata = ram[{2'b00, stack_pointer_low}];                   // see RULE16
        next_spl         = stack_pointer_low + 8'h01;                         // see RULE17
      end
      mpb_pkg::MPB_OP_NONE, mpb_pkg::MPB_OP_HOLD: ;
      default: ;
    endcase
    // constant load auto-toggle
    if (const_load && const_inc && const_addr == 16'hFFFF &&
        constant_page_select[mpb_pkg::TOGGLE_BIT_POS])
      next_cps[mpb_pkg::PAGE_BIT_POS] = ~constant_page_select[mpb_pkg::PAGE_BIT_POS];  // see RULE7
  end

  // vector slot address, index above the last slot clamps to it
  function automatic logic [15:0] vector_word(input logic [2:0] idx);
    logic [2:0] v;
    v = (idx > 3'd5) ? 3'd5 : idx;
    vector_word = mpb_pkg::VECTOR_BASE + {12'h000, v, 1'b0};
  endfunction : vector_word

  // program counter and constant address
  always_comb begin
    next_pc = pc;
    if (vector_take)
      next_pc = vector_word(vector_index);                                    // see RULE2
    else if (fetch_jump)
      next_pc = fetch_target;
    else if (fetch_step)
      next_pc = pc + 16'h0001;                                                // see RULE3
    next_fetch_addr = {1'b0, next_pc};                                        // see RULE4
    next_const_addr = {constant_page_select[mpb_pkg::PAGE_BIT_POS], const_addr};  // see RULE5 see RULE6
    next_const_rd   = const_load;
  end

  always_ff @(posedge ref_clk) begin
    if (ram_we)
      ram[ram_wa] <= ram_wd;
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      constant_page_select <= 8'h00;                                          // see RULE6
      bank_group_pointer   <= mpb_pkg::POINTER_RESET;
      scratch_user_byte    <= mpb_pkg::SCRATCH_RESET;
      stack_pointer_low    <= mpb_pkg::STACK_RESET;
      pc                   <= mpb_pkg::RESET_FETCH_ADDR;                      // see RULE1
      fetch_addr           <= {1'b0, mpb_pkg::RESET_FETCH_ADDR};             // see RULE1
      const_mem_addr       <= 17'h0_0000;
      const_mem_rd         <= 1'b0;
      reg_rdata            <= 8'h00;
      reg_rvalid           <= 1'b0;
      reg_phys             <= 12'h000;
      reg_port_sel         <= 1'b0;
      stack_rdata          <= 8'h00;
    end else begin
      constant_page_select <= next_cps;
      bank_group_pointer   <= next_bgp;
      scratch_user_byte    <= next_sub;
      stack_pointer_low    <= next_spl;
      pc                   <= next_pc;
      fetch_addr           <= next_fetch_addr;
      const_mem_addr       <= next_const_addr;
      const_mem_rd         <= next_const_rd;
      reg_rdata            <= next_rdata;
      reg_rvalid           <= next_rvalid;
      reg_phys             <= next_phys;
      reg_port_sel         <= next_port;
      stack_rdata          <= next_stack_rdata;
    end
  end

  assign stack_ptr = stack_pointer_low;
  assign pointer_q = bank_group_pointer;
  assign page_q    = constant_page_select[mpb_pkg::PAGE_BIT_POS];
endmodule : mpb_memory_page_bank_decoder

// ==== shared/mpb_pkg.sv ====
// package: constants, types and rule notes for the memory page / bank decoder
// assumes a single core clock domain shared with the fetch/execute logic
// Notes on behaviour
// RULE1: reset starts fetch at 000Ch, page 0
// RULE2: first 12 bytes hold six 16-bit vectors
// RULE3: program counter wraps FFFFh to 0000h, page 0
// RULE4: page 1 serves constant reads only
// RULE5: constants reached only by constant loads, 16-bit address
// RULE6: page bit 0 picks constant page, reset 0
// RULE7: toggle enable flips page bit on rollover
// RULE8: bits 6:1 read ones; software writes zeros
// RULE9: 256-byte banks; 0-3 RAM, D/F control
// RULE10: pointer low nibble bank, high nibble group
// RULE11: F0h-FFh always decode to bank 0
// RULE12: 00h-03h are bank 0 ports unless D/F
// RULE13: bank D/F maps 10h-EFh to bank 0
// RULE14: extended loads use 12-bit linear address pair
// RULE15: hidden bank 1-3 bytes reachable linearly/indirectly
// RULE16: stack always bank 0 via pointer FFh
// RULE17: pre-decrement push, post-increment pop
// RULE18: call pushes PC; interrupt pushes PC and flags
// RULE19: bank nibble 0 normal; nonzero swaps expanded bank
// RULE20: FEh scratch byte; avoid as loop counter
// RULE21: reserved or unimplemented: writes ignored, reads stable
package mpb_pkg;
  localparam logic [15:0] RESET_FETCH_ADDR = 16'h000C;
  localparam logic [15:0] VECTOR_BASE      = 16'h0000;
  localparam logic [7:0]  ADDR_PAGE_SEL    = 8'hF0;
  localparam logic [7:0]  ADDR_POINTER     = 8'hFD;
  localparam logic [7:0]  ADDR_SCRATCH     = 8'hFE;
  localparam logic [7:0]  ADDR_STACK_LOW   = 8'hFF;
  localparam int          PAGE_BIT_POS     = 0;
  localparam int          TOGGLE_BIT_POS   = 7;
  localparam logic [5:0]  PAGE_RSVD_READ   = 6'h3F;
  localparam logic [7:0]  POINTER_RESET    = 8'h00;
  localparam logic [7:0]  STACK_RESET      = 8'h00;
  localparam logic [7:0]  SCRATCH_RESET    = 8'h00;
  localparam logic [3:0]  BANK_D           = 4'hD;
  localparam logic [3:0]  BANK_F           = 4'hF;
  localparam logic [7:0]  UNMAPPED_READ    = 8'hFF;
  localparam logic [7:0]  CTRL_WIN_LO      = 8'hF0;
  localparam logic [7:0]  PORT_WIN_HI      = 8'h03;
  localparam logic [7:0]  GP_WIN_LO        = 8'h10;
  localparam logic [7:0]  GP_WIN_HI        = 8'hEF;

  typedef enum logic [3:0] {
    MPB_OP_NONE  = 4'b0001,
    MPB_OP_PUSH  = 4'b0010,
    MPB_OP_POP   = 4'b0100,
    MPB_OP_HOLD  = 4'b1000
  } mpb_stack_op_e;

  // register file access from the core
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        linear;   // 12-bit address supplied directly
    logic        working;  // 4-bit working-register operand
    logic [11:0] addr;
    logic [7:0]  wdata;
  } mpb_reg_req_s;

  // decoded physical target
  typedef struct packed {
    logic        hit;
    logic        ctrl;     // bank 0 control window
    logic        port;
    logic [11:0] phys;
  } mpb_decode_s;
endpackage : mpb_pkg

// ==== src/mpb_bank_decode.sv ====
// bank / working-group address translator for the register file
// assumes pointer value comes from the same clock domain
`timescale 1ns/1ps
module mpb_bank_decode (
  // request
  input  wire logic [7:0]          pointer,
  input  wire mpb_pkg::mpb_reg_req_s req,
  // result
  output mpb_pkg::mpb_decode_s     dec
);
  function automatic logic implemented(input logic [11:0] a);
    logic [3:0] b;
    b = a[11:8];
    if (b == 4'h0) implemented = (a[7:0] != 8'h01);                  // see RULE12
    else if (b <= 4'h3) implemented = 1'b1;                          // see RULE9
    else if (b == mpb_pkg::BANK_D || b == mpb_pkg::BANK_F)
      implemented = (a[7:0] < 8'h10);
    else implemented = 1'b0;                                         // see RULE21
  endfunction : implemented

  logic [7:0]  a8;
  logic [3:0]  bank;
  logic [11:0] phys;

  always_comb begin
    bank = pointer[3:0];                                             // see RULE10
    a8   = req.working ? {pointer[7:4], req.addr[3:0]} : req.addr[7:0];
    if (req.linear) begin
      phys = req.addr;                                               // see RULE14 see RULE15
    end else if (a8 >= mpb_pkg::CTRL_WIN_LO) begin
      phys = {4'h0, a8};                                             // see RULE11
    end else if (bank == 4'h0) begin
      phys = {4'h0, a8};                                             // see RULE19
    end else if (bank == mpb_pkg::BANK_D || bank == mpb_pkg::BANK_F) begin
      phys = (a8 >= mpb_pkg::GP_WIN_LO) ? {4'h0, a8} : {bank, a8};   // see RULE13
    end else if (a8 <= mpb_pkg::PORT_WIN_HI) begin
      phys = {4'h0, a8};                                             // see RULE12
    end else begin
      phys = {bank, a8};                                             // see RULE19
    end
    dec.phys = phys;
    dec.hit  = req.valid && implemented(phys);
    dec.ctrl = (phys[11:8] == 4'h0) && (phys[7:0] >= mpb_pkg::CTRL_WIN_LO);
    dec.port = (phys[11:8] == 4'h0) && (phys[7:0] <= mpb_pkg::PORT_WIN_HI);
  end
endmodule : mpb_bank_decode

// ==== tb/mpb_checker.sv ====
// checker: port-level timing and decode relations of the page/bank decoder
// assumes one clock domain, resetn asynchronous active low
`timescale 1ns/1ps
module mpb_checker (
  input wire logic                   ref_clk, resetn, fetch_step, fetch_jump, vector_take,
  input wire logic                   const_load, const_inc, const_mem_rd, reg_rvalid, page_q,
  input wire logic [2:0]             vector_index,
  input wire logic [15:0]            const_addr,
  input wire logic [16:0]            fetch_addr, const_mem_addr,
  input wire logic [11:0]            reg_phys,
  input wire logic [7:0]             stack_ptr,
  input wire mpb_pkg::mpb_reg_req_s  reg_req,
  input wire mpb_pkg::mpb_stack_op_e stack_op
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  wire [2:0] vclamp = (vector_index > 3'd5) ? 3'd5 : vector_index;
  wire       rd_8   = reg_req.valid && !reg_req.write && !reg_req.linear && !reg_req.working;

  a_reset_fetch: assert property ($rose(resetn) |-> fetch_addr == 17'h0000C)
    else $error("fetch not at reset address");
  a_fetch_page0: assert property (fetch_addr[16] == 1'b0)
    else $error("fetch left page 0");
  a_pc_wrap: assert property (fetch_step && !fetch_jump && !vector_take
    |=> fetch_addr[15:0] == $past(fetch_addr[15:0]) + 16'h0001)
    else $error("program counter step wrong");
  a_vector_entry: assert property (vector_take && !fetch_jump && !fetch_step
    |=> fetch_addr == {13'h0000, $past(vclamp), 1'b0})
    else $error("vector fetch address wrong");
  a_const_page: assert property (const_load
    |=> const_mem_rd && const_mem_addr == {$past(page_q), $past(const_addr)})
    else $error("constant address wrong");
  a_page_cause: assert property ($changed(page_q) |-> $past(const_load && const_inc && const_addr == 16'hFFFF)
    || $past(reg_req.valid && reg_req.write))
    else $error("page bit changed without cause");
  a_stack_push: assert property (stack_op == mpb_pkg::MPB_OP_PUSH
    |=> stack_ptr == $past(stack_ptr) - 8'h01)
    else $error("push did not predecrement");
  a_stack_pop: assert property (stack_op == mpb_pkg::MPB_OP_POP
    |=> stack_ptr == $past(stack_ptr) + 8'h01)
    else $error("pop did not postincrement");
  a_ctrl_window: assert property (rd_8 && reg_req.addr[7:4] == 4'hF
    |=> reg_phys == {4'h0, $past(reg_req.addr[7:0])})
    else $error("control window not bank 0");
  a_read_answer: assert property (reg_req.valid && !reg_req.write |=> reg_rvalid)
    else $error("read not answered");
endmodule : mpb_checker

bind mpb_memory_page_bank_decoder mpb_checker u_chk (.ref_clk, .resetn, .fetch_step, .fetch_jump, .vector_take,
  .const_load, .const_inc, .const_mem_rd, .reg_rvalid, .page_q, .vector_index, .const_addr, .fetch_addr,
  .const_mem_addr, .reg_phys, .stack_ptr, .reg_req, .stack_op);

// ==== tb/mpb_core_model.sv ====
// core-side model: packs register access commands into the request struct
// assumes bench sequences the commands one access at a time
`timescale 1ns/1ps
module mpb_core_model (
  // command
  input wire logic        go, wr, lin,
  input wire logic [11:0] a,
  input wire logic [7:0]  d,
  // request to block
  output mpb_pkg::mpb_reg_req_s req
);
  wire pg_wr = (a[7:0] == 8'hF0) && (!lin || a[11:8] == 4'h0);
  // idle addr and wdata fields show inverted values, never the stale ones
  assign req = '{valid: go, write: wr, linear: lin, working: 1'b0, addr: go ? a : ~a,
                 wdata: go ? (pg_wr ? (d & 8'h81) : d) : ~d};
endmodule : mpb_core_model

// ==== tb/mpb_memory_page_bank_decoder_bench.sv ====
// bench: fetch, constant paging, bank decode and stack scenarios
// assumes 250 MHz ref_clk, inputs driven at falling edge
`timescale 1ns/1ps
module mpb_memory_page_bank_decoder_bench;
  logic ref_clk = 0, resetn = 0, fs = 0, fj = 0, vt = 0, cl = 0, ci = 0, go = 0, wr = 0, lin = 0;
  logic [2:0] vi = 0;
  logic [15:0] ft = 0, ca = 0;
  logic [11:0] a = 0, ph;
  logic [7:0] d = 0, sw = 0, rdat, srd, sp, pq;
  logic [16:0] fa, cma;
  logic cmr, rv, ps, pg;
  mpb_pkg::mpb_stack_op_e so = mpb_pkg::MPB_OP_NONE;
  mpb_pkg::mpb_reg_req_s rq;
  int n_errors = 0, cmp_count = 0;

  mpb_core_model core (.go(go), .wr(wr), .lin(lin), .a(a), .d(d), .req(rq));
  mpb_memory_page_bank_decoder uut (.ref_clk(ref_clk), .resetn(resetn), .fetch_step(fs), .fetch_jump(fj),
    .fetch_target(ft), .vector_take(vt), .vector_index(vi), .fetch_addr(fa), .const_load(cl), .const_inc(ci),
    .const_addr(ca), .const_mem_addr(cma), .const_mem_rd(cmr), .reg_req(rq), .reg_rdata(rdat), .reg_rvalid(rv),
    .reg_phys(ph), .reg_port_sel(ps), .stack_op(so), .stack_wdata(sw), .stack_rdata(srd), .stack_ptr(sp),
    .pointer_q(pq), .page_q(pg));

  initial begin
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic pulse(ref logic s);
    @(negedge ref_clk);
    s = 1;
    @(negedge ref_clk);
    s = 0;
  endtask : pulse

  task automatic acc(input logic w, input logic l, input logic [11:0] ad, input logic [7:0] wd);
    @(negedge ref_clk);
    wr = w; lin = l; a = ad; d = wd; go = 1;
    @(negedge ref_clk);
    go = 0;
  endtask : acc

  task automatic sop(input mpb_pkg::mpb_stack_op_e o, input logic [7:0] w);
    @(negedge ref_clk);
    so = o; sw = w;
    @(negedge ref_clk);
    so = mpb_pkg::MPB_OP_NONE;
  endtask : sop

  task automatic t_reset_state();
    chk(fa, 17'h0000C);
    chk(pg, 17'h0);
    acc(0, 0, 12'h0F0, 8'h00);
    chk(rdat, 17'h0007E);
  endtask : t_reset_state

  task automatic t_fetch();
    pulse(fs);
    chk(fa, 17'h0000D);
    ft = 16'hFFFF;
    pulse(fj);
    pulse(fs);
    chk(fa, 17'h00000);
    for (int i = 0; i < 8; i++) begin
      vi = i[2:0];
      pulse(vt);
      chk(fa, {13'h0000, (i > 5) ? 3'd5 : i[2:0], 1'b0});
    end
  endtask : t_fetch

  task automatic t_const();
    acc(1, 0, 12'h0F0, 8'h80);
    ci = 1; ca = 16'hFFFF;
    pulse(cl);
    chk({16'h0000, cmr}, 17'h00001);
    chk(cma, 17'h0FFFF);
    chk(pg, 17'h1);
    ca = 16'h0000;
    pulse(cl);
    chk(cma, 17'h10000);
    acc(0, 0, 12'h0F0, 8'h00);
    chk(rdat, 17'h000FF);
    ci = 0; ca = 16'hFFFF;
    pulse(cl);
    chk(pg, 17'h1);
    acc(1, 0, 12'h0F0, 8'h00);
    chk(pg, 17'h0);
  endtask : t_const

  task automatic t_bank();
    acc(1, 0, 12'h0FD, 8'h21);
    chk(pq, 17'h00021);
    acc(1, 0, 12'h010, 8'h33);
    acc(0, 0, 12'h010, 8'h00);
    chk(ph, 17'h00110);
    acc(0, 0, 12'h0F3, 8'h00);
    chk(ph, 17'h000F3);
    acc(0, 0, 12'h002, 8'h00);
    chk({ps, ph}, 17'h01002);
    acc(0, 1, 12'h110, 8'h00);
    chk(rdat, 17'h00033);
    acc(1, 1, 12'h1F0, 8'h5A);
    acc(0, 1, 12'h1F0, 8'h00);
    chk(rdat, 17'h0005A);
    acc(1, 0, 12'h0FD, 8'h0D);
    acc(0, 0, 12'h020, 8'h00);
    chk(ph, 17'h00020);
    acc(0, 0, 12'h002, 8'h00);
    chk(ps, 17'h0);
    acc(1, 1, 12'h400, 8'h11);
    acc(0, 1, 12'h400, 8'h00);
    chk({rv, rdat}, 17'h001FF);
    acc(1, 0, 12'h0FE, 8'hC3);
    acc(1, 0, 12'h0FD, 8'h00);
    acc(0, 0, 12'h0FE, 8'h00);
    chk(rdat, 17'h000C3);
  endtask : t_bank

  task automatic t_stack();
    acc(1, 0, 12'h0FD, 8'h01);
    acc(1, 0, 12'h0FF, 8'h80);
    sop(mpb_pkg::MPB_OP_PUSH, 8'hA1);
    chk(sp, 17'h0007F);
    sop(mpb_pkg::MPB_OP_PUSH, 8'hB2);
    acc(0, 1, 12'h07F, 8'h00);
    chk(rdat, 17'h000A1);
    sop(mpb_pkg::MPB_OP_POP, 8'h00);
    chk({srd, sp}, 17'h0B27F);
    sop(mpb_pkg::MPB_OP_POP, 8'h00);
    chk({srd, sp}, 17'h0A180);
  endtask : t_stack

  task automatic report_and_stop();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : report_and_stop

  initial begin
    #100000;
    n_errors++;
    report_and_stop();
  end

  initial begin
    repeat (3) @(negedge ref_clk);
    resetn = 1;
    t_reset_state();
    t_fetch();
    t_const();
    t_bank();
    t_stack();
    report_and_stop();
  end
endmodule : mpb_memory_page_bank_decoder_bench
